/* File: common/pslm_pkg.sv */
package pslm_pkg;
	// ***************************************************************
	// clock and tick timing
	// ***************************************************************
	localparam int unsigned CLK_HZ = 200000000;
	localparam int unsigned TICK_MS = 250;
	localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned TPS = 1000 / TICK_MS;
	localparam int unsigned RADIO_TMO_S = 300;
	localparam int unsigned TOP_TMO_S = 30;
	localparam int unsigned WAKE_LEAD_S = 15;
	localparam int unsigned SLOW_BLINK_S = 10;
	localparam logic [10:0] RADIO_TMO_T = 11'(RADIO_TMO_S * TPS);
	localparam logic [10:0] TOP_TMO_T = 11'(TOP_TMO_S * TPS);
	localparam logic [5:0] SLOW_T = 6'(SLOW_BLINK_S * TPS);
	localparam logic [1:0] TPS_LAST = 2'(TPS - 1);
	localparam logic [15:0] WAKE_LEAD_V = 16'(WAKE_LEAD_S);

	// ***************************************************************
	// register map
	// ***************************************************************
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_LOGIV = 8'h08;
	localparam logic [7:0] A_RTIV = 8'h0c;
	localparam logic [7:0] A_ISTAT = 8'h10;
	localparam logic [7:0] A_IMASK = 8'h14;
	localparam int unsigned CTRL_LOG = 0;
	localparam int unsigned CTRL_MODE = 1;
	localparam int unsigned CTRL_RADIO = 3;
	localparam logic [2:0] CTRL_RST = 3'h0;
	localparam logic [15:0] LOGIV_RST = 16'h0384;
	localparam logic [7:0] RTIV_RST = 8'h02;
	localparam int unsigned IRQ_W = 4;
	localparam int unsigned IRQ_WAKE = 0;
	localparam int unsigned IRQ_SLEEP = 1;
	localparam int unsigned IRQ_FAULT = 2;
	localparam int unsigned IRQ_SAMPLE = 3;
	localparam int unsigned NSYNC = 7;

	typedef enum logic [1:0] {PSLM_OFF, PSLM_ASLEEP, PSLM_AWAKE} pslm_state_e;
	typedef enum logic [1:0] {MODE_INACTIVE, MODE_REALTIME, MODE_SAMPHOLD}
		pslm_mode_e;
endpackage : pslm_pkg

/* File: rtl/pslm_sync.sv */
`timescale 1ns/10ps
module pslm_sync #(
	parameter int unsigned W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	// ***************************************************************
	// three-stage synchroniser, accept once stages two and three agree
	// ***************************************************************
	genvar i;
	for (i = 0; i < W; i++) begin : g_bit
		logic s1_q;
		logic s2_q;
		logic s3_q;
		logic out_q;
		always_ff @(posedge clk) begin
			if (rst) begin
				s1_q <= 1'b0;
				s2_q <= 1'b0;
				s3_q <= 1'b0;
				out_q <= 1'b0;
			end else begin
				s1_q <= din[i];
				s2_q <= s1_q;
				s3_q <= s2_q;
				// filters a glitch that reaches only one stage
				if (s2_q == s3_q) begin
					out_q <= s3_q;
				end
			end
		end
		assign dout[i] = out_q;
	end
endmodule : pslm_sync

/* File: rtl/pslm_top.sv */
`timescale 1ns/10ps
// Overview of operation
// - always exactly one of off, asleep, awake; off never samples
// - with power present (from the first clock out of reset) state is only asleep or awake
// - asleep waits only for a command, a wake source or schedule
// - radio led: dark disabled, solid unlinked, 0.5 s blink when linked
// - state led dark when off, or asleep with logging disabled
// - asleep with logging on: state led flashes once per 10 s
// - awake without fault: state led blinks at 1 Hz
// - awake with fault: state led lit solid
// - stay awake until 5 min after last wireless traffic
// - stay awake until 30 s after last topside traffic
// - wake by itself 15 s before each scheduled sample
// - both timers expired: radio off and go to sleep
// - magnet detection wakes the unit and enables radio
// - power cycle, topside traffic or sensor insertion wakes unit
// - radio enabled after power cycle or by a host enable command
// - awake modes: inactive, real-time at set interval, sample/hold
module pslm_top #(
	parameter int unsigned TICK_CYCLES = pslm_pkg::TICK_CYC
) (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic MAGNET,
	input wire logic TOP_ACT,
	input wire logic RADIO_RX,
	input wire logic RADIO_LINK,
	input wire logic SENSOR_INS,
	input wire logic FAULT,
	input wire logic HOLD_SYNC,
	output logic IRQ,
	output logic LED_RADIO,
	output logic LED_STATE,
	output logic RADIO_EN,
	output logic [1:0] PWR_STATE,
	output logic SAMPLE
);
	import pslm_pkg::*;

	// ***************************************************************
	// pin synchronisers and edges
	// ***************************************************************
	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] pin_s;
	logic [NSYNC-1:0] pin_prev_q;
	logic [NSYNC-1:0] pin_rise;
	assign pin_raw = {HOLD_SYNC, FAULT, SENSOR_INS, RADIO_LINK, RADIO_RX,
		TOP_ACT, MAGNET};

	pslm_sync #(.W(NSYNC)) u_sync (
		.clk(CORE_CLK),
		.rst(RST),
		.din(pin_raw),
		.dout(pin_s)
	);

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			pin_prev_q <= '0;
		end else begin
			pin_prev_q <= pin_s;
		end
	end
	assign pin_rise = pin_s & ~pin_prev_q;

	wire mag_rise = pin_rise[0];
	wire top_rise = pin_rise[1];
	wire rrx_rise = pin_rise[2];
	wire link_s = pin_s[3];
	wire sens_rise = pin_rise[4];
	wire fault_s = pin_s[5];
	wire fault_rise = pin_rise[5];
	wire hold_rise = pin_rise[6];

	// ***************************************************************
	// prescaled tick, one source for all timing
	// ***************************************************************
	logic [31:0] pre_q;
	logic tick_q;
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			pre_q <= '0;
			tick_q <= 1'b0;
		end else begin
			tick_q <= (pre_q == TICK_CYCLES - 1);
			pre_q <= (pre_q == TICK_CYCLES - 1) ? '0 : pre_q + 32'h1;
		end
	end

	// ***************************************************************
	// ahb-lite slave
	// ***************************************************************
	logic wr_pend_q;
	logic [7:0] waddr_q;
	logic [31:0] hrdata_q;
	logic [2:0] ctrl_q;
	logic [15:0] logiv_q;
	logic [7:0] rtiv_q;
	logic [IRQ_W-1:0] istat_q;
	logic [IRQ_W-1:0] imask_q;
	pslm_state_e state_q;
	logic radio_q;
	logic [31:0] rd_mux;

	wire ahb_sel = HSEL & HTRANS[1] & HREADY;
	wire [7:0] raddr = HADDR[7:0];
	wire wr_ctrl = wr_pend_q & (waddr_q == A_CTRL);
	wire wr_logiv = wr_pend_q & (waddr_q == A_LOGIV);
	wire wr_rtiv = wr_pend_q & (waddr_q == A_RTIV);
	wire wr_istat = wr_pend_q & (waddr_q == A_ISTAT);
	wire wr_imask = wr_pend_q & (waddr_q == A_IMASK);
	wire [31:0] stat_word = {26'h0, fault_s, link_s, radio_q, 1'b0, state_q};

	// unmapped offsets read zero, writes dropped, answer still okay
	assign rd_mux = (raddr == A_CTRL) ? {29'h0, ctrl_q} :
		(raddr == A_STAT) ? stat_word :
		(raddr == A_LOGIV) ? {16'h0, logiv_q} :
		(raddr == A_RTIV) ? {24'h0, rtiv_q} :
		(raddr == A_ISTAT) ? {28'h0, istat_q} :
		(raddr == A_IMASK) ? {28'h0, imask_q} : 32'h0;

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			wr_pend_q <= 1'b0;
			waddr_q <= 8'h00;
			hrdata_q <= 32'h0;
		end else begin
			wr_pend_q <= ahb_sel & HWRITE;
			waddr_q <= raddr;
			if (ahb_sel & ~HWRITE) begin
				hrdata_q <= rd_mux;
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			ctrl_q <= CTRL_RST;
			logiv_q <= LOGIV_RST;
			rtiv_q <= RTIV_RST;
			imask_q <= '0;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= HWDATA[2:0];
			end
			if (wr_logiv) begin
				logiv_q <= HWDATA[15:0];
			end
			if (wr_rtiv) begin
				rtiv_q <= HWDATA[7:0];
			end
			if (wr_imask) begin
				imask_q <= HWDATA[IRQ_W-1:0];
			end
		end
	end

	wire log_en = ctrl_q[CTRL_LOG];
	wire [1:0] mode = ctrl_q[CTRL_MODE+1:CTRL_MODE];
	// a host write over the cable also counts as topside traffic
	wire host_cmd = wr_pend_q;
	wire radio_cmd = wr_ctrl & HWDATA[CTRL_RADIO];

	// ***************************************************************
	// logging schedule, seconds since last scheduled sample
	// ***************************************************************
	logic [1:0] sub_q;
	logic [15:0] sec_q;
	wire sec_tick = tick_q & (sub_q == TPS_LAST);
	wire sched_on = log_en & (logiv_q != 16'h0);
	wire [15:0] remain = logiv_q - sec_q;
	wire log_due = sched_on & sec_tick & (sec_q == logiv_q - 16'h1);
	wire sched_wake = sched_on & (remain <= WAKE_LEAD_V);

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			sub_q <= 2'h0;
			sec_q <= 16'h0;
		end else begin
			if (tick_q) begin
				sub_q <= (sub_q == TPS_LAST) ? 2'h0 : sub_q + 2'h1;
			end
			// a new interval restarts the count, else a shorter one is missed
			if (!sched_on || log_due || wr_logiv) begin
				sec_q <= 16'h0;
			end else if (sec_tick) begin
				sec_q <= sec_q + 16'h1;
			end
		end
	end

	// ***************************************************************
	// power state machine and inactivity timers
	// ***************************************************************
	pslm_state_e state_d;
	logic [10:0] rtmr_q;
	logic [10:0] ttmr_q;
	// asleep only these sources are looked at
	wire wake_req = mag_rise | top_rise | sens_rise |
		host_cmd | sched_wake;
	wire tmr_idle = (rtmr_q == 11'h0) & (ttmr_q == 11'h0);
	wire go_sleep = (state_q == PSLM_AWAKE) & tmr_idle & ~wake_req;
	wire from_off = (state_q == PSLM_OFF);
	wire go_wake = from_off | ((state_q == PSLM_ASLEEP) & wake_req);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			PSLM_OFF: state_d = PSLM_AWAKE;
			PSLM_ASLEEP: begin
				if (wake_req) begin
					state_d = PSLM_AWAKE;
				end
			end
			PSLM_AWAKE: begin
				if (go_sleep) begin
					state_d = PSLM_ASLEEP;
				end
			end
			default: state_d = PSLM_AWAKE;
		endcase
	end

	// any wake keeps the unit up for at least one topside window
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			state_q <= PSLM_OFF;
			ttmr_q <= 11'h0;
			rtmr_q <= 11'h0;
		end else begin
			state_q <= state_d;
			if (go_wake | top_rise | host_cmd) begin
				ttmr_q <= TOP_TMO_T;
			end else if (tick_q && ttmr_q != 11'h0) begin
				ttmr_q <= ttmr_q - 11'h1;
			end
			if (from_off | mag_rise | (rrx_rise & radio_q)) begin
				rtmr_q <= RADIO_TMO_T;
			end else if (tick_q && rtmr_q != 11'h0) begin
				rtmr_q <= rtmr_q - 11'h1;
			end
		end
	end

	// enable wins over the sleep-time disable
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			radio_q <= 1'b0;
		end else if (from_off | mag_rise | radio_cmd) begin
			radio_q <= 1'b1;
		end else if (go_sleep) begin
			radio_q <= 1'b0;
		end
	end

	// ***************************************************************
	// awake sampling modes
	// ***************************************************************
	logic [7:0] rt_q;
	logic sample_q;
	wire awake = (state_q == PSLM_AWAKE);
	wire rt_mode = awake & (mode == MODE_REALTIME);
	wire rt_hit = rt_mode & tick_q & (rt_q == 8'h0) & (rtiv_q != 8'h0);
	wire sh_hit = awake & (mode == MODE_SAMPHOLD) & hold_rise;
	// code 3 in the mode field behaves as inactive
	wire sample_d = awake & (rt_hit | sh_hit | log_due);

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			rt_q <= 8'h0;
			sample_q <= 1'b0;
		end else begin
			sample_q <= sample_d;
			if (!rt_mode) begin
				rt_q <= 8'h0;
			end else if (tick_q) begin
				rt_q <= (rt_q == 8'h0) ? rtiv_q - 8'h1 : rt_q - 8'h1;
			end
		end
	end

	// ***************************************************************
	// indicator leds
	// ***************************************************************
	logic [5:0] ph_q;
	logic led_r_q;
	logic led_s_q;
	wire led_r_d = radio_q & (~link_s | ph_q[0]);
	wire slow_on = (state_q == PSLM_ASLEEP) & log_en & (ph_q == 6'h0);
	wire fast_on = awake & (fault_s | ph_q[1]);
	// off, or asleep with logging disabled, leaves both terms low
	wire led_s_d = slow_on | fast_on;

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			ph_q <= 6'h0;
			led_r_q <= 1'b0;
			led_s_q <= 1'b0;
		end else begin
			led_r_q <= led_r_d;
			led_s_q <= led_s_d;
			if (tick_q) begin
				ph_q <= (ph_q == SLOW_T - 6'h1) ? 6'h0 : ph_q + 6'h1;
			end
		end
	end

	// ***************************************************************
	// interrupt status and mask
	// ***************************************************************
	logic [IRQ_W-1:0] ev;
	logic irq_q;
	assign ev[IRQ_WAKE] = go_wake;
	assign ev[IRQ_SLEEP] = go_sleep;
	assign ev[IRQ_FAULT] = fault_rise;
	assign ev[IRQ_SAMPLE] = sample_d;
	wire [IRQ_W-1:0] w1c = wr_istat ? HWDATA[IRQ_W-1:0] : '0;

	// a set in the clearing cycle survives
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			istat_q <= '0;
			irq_q <= 1'b0;
		end else begin
			istat_q <= (istat_q & ~w1c) | ev;
			irq_q <= |(istat_q & imask_q);
		end
	end

	// ***************************************************************
	// outputs
	// ***************************************************************
	logic hready_q;
	logic hresp_q;
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			hready_q <= 1'b1;
			hresp_q <= 1'b0;
		end else begin
			hready_q <= 1'b1;
			hresp_q <= 1'b0;
		end
	end

	assign HRDATA = hrdata_q;
	assign HREADYOUT = hready_q;
	assign HRESP = hresp_q;
	assign IRQ = irq_q;
	assign LED_RADIO = led_r_q;
	assign LED_STATE = led_s_q;
	assign RADIO_EN = radio_q;
	assign PWR_STATE = state_q;
	assign SAMPLE = sample_q;
endmodule : pslm_top

/* File: dv/pslm_host.sv */
`timescale 1ns/10ps
module pslm_host (
	input wire logic CORE_CLK,
	output logic TOP_ACT,
	output logic RADIO_RX
);
	// ****
	// host traffic model
	// ****
	initial begin
		TOP_ACT = 1'b0;
		RADIO_RX = 1'b0;
	end
	// one pulse is one message; len sets a prompt or slow sender
	task automatic msg(input logic radio, input int len);
		@(posedge CORE_CLK);
		if (radio) begin
			RADIO_RX <= 1'b1;
		end else begin
			TOP_ACT <= 1'b1;
		end
		repeat (len) @(posedge CORE_CLK);
		RADIO_RX <= 1'b0;
		TOP_ACT <= 1'b0;
	endtask : msg
endmodule : pslm_host

/* File: dv/pslm_checker.sv */
`timescale 1ns/10ps
module pslm_checker (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic MAGNET,
	input wire logic SENSOR_INS,
	input wire logic FAULT,
	input wire logic RADIO_EN,
	input wire logic LED_RADIO,
	input wire logic LED_STATE,
	input wire logic [1:0] PWR_STATE,
	input wire logic SAMPLE
);
	// ****
	// power state, radio and led checks
	// ****
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (RST);
	sequence s_fault_held;
		(PWR_STATE == 2'h2 && FAULT) [*8];
	endsequence
	chk_state_legal: assert property (PWR_STATE != 2'h3)
		else $error("illegal power state");
	chk_sample_awake: assert property (SAMPLE |-> PWR_STATE == 2'h2)
		else $error("sample outside awake");
	chk_never_off: assert property (!$past(RST) && !$past(RST, 2) &&
		!$past(RST, 3) |-> PWR_STATE != 2'h0)
		else $error("off while powered");
	chk_powerup_wake: assert property ($fell(RST) |->
		##[1:3] (PWR_STATE == 2'h2 && RADIO_EN))
		else $error("no wake after power up");
	chk_radio_dark: assert property (!RADIO_EN && !$past(RADIO_EN)
		|-> !LED_RADIO)
		else $error("radio led lit while disabled");
	chk_off_dark: assert property (PWR_STATE == 2'h0 |-> !LED_STATE)
		else $error("state led lit while off");
	chk_fault_solid: assert property (s_fault_held |=> LED_STATE)
		else $error("fault led not solid");
	chk_magnet_wake: assert property ($rose(MAGNET) |->
		##[1:10] (PWR_STATE == 2'h2 && RADIO_EN))
		else $error("magnet did not wake");
	chk_sensor_wake: assert property ($rose(SENSOR_INS) |->
		##[1:10] PWR_STATE == 2'h2)
		else $error("sensor insert did not wake");
	chk_sleep_radio: assert property ($rose(PWR_STATE == 2'h1) |->
		##[0:1] !RADIO_EN)
		else $error("radio on after sleep");
endmodule : pslm_checker

bind pslm_top pslm_checker chk_i (.CORE_CLK(CORE_CLK), .RST(RST),
	.MAGNET(MAGNET), .SENSOR_INS(SENSOR_INS), .FAULT(FAULT),
	.RADIO_EN(RADIO_EN), .LED_RADIO(LED_RADIO), .LED_STATE(LED_STATE),
	.PWR_STATE(PWR_STATE), .SAMPLE(SAMPLE));

/* File: dv/tb.sv */
`timescale 1ns/10ps
module tb;
	import pslm_pkg::*;
	// ****
	// bench
	// ****
	localparam int unsigned TC = 20;
	logic CORE_CLK = 1'b0;
	logic RST = 1'b1;
	logic HSEL = 1'b0;
	logic HWRITE = 1'b0;
	logic [31:0] HADDR = 32'h0;
	logic [31:0] HWDATA = 32'h0;
	logic [1:0] HTRANS = 2'h0;
	logic [2:0] HSIZE = 3'h2;
	logic MAGNET = 1'b0;
	logic RADIO_LINK = 1'b0;
	logic SENSOR_INS = 1'b0;
	logic FAULT = 1'b0;
	logic HOLD_SYNC = 1'b0;
	logic HREADY, HREADYOUT, HRESP, TOP_ACT, RADIO_RX, IRQ;
	logic LED_RADIO, LED_STATE, RADIO_EN, SAMPLE;
	logic [31:0] HRDATA, rv;
	logic [1:0] PWR_STATE;
	int err_count = 0;
	int check_count = 0;
	int n, n_st, n_rt, n_sp;
	always #2.5 CORE_CLK = ~CORE_CLK;
	// one slave, so its ready is the bus ready
	assign HREADY = (HREADYOUT !== 1'b0);
	pslm_top #(.TICK_CYCLES(TC)) DUT (.CORE_CLK, .RST, .HSEL, .HADDR,
		.HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY, .HRDATA, .HREADYOUT,
		.HRESP, .MAGNET, .TOP_ACT, .RADIO_RX, .RADIO_LINK, .SENSOR_INS,
		.FAULT, .HOLD_SYNC, .IRQ, .LED_RADIO, .LED_STATE, .RADIO_EN,
		.PWR_STATE, .SAMPLE);
	pslm_host host (.CORE_CLK, .TOP_ACT, .RADIO_RX);
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s exp %h got %h", s, e, g);
		end
	endtask : chk
	task cyc(input int k);
		repeat (k) @(posedge CORE_CLK);
	endtask : cyc
	// leading edge gives an idle cycle, so read after write is safe
	task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge CORE_CLK);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HWRITE <= w;
		HADDR <= {24'h0, a};
		do @(posedge CORE_CLK); while (HREADY !== 1'b1);
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= d;
		do @(posedge CORE_CLK); while (HREADY !== 1'b1);
		rv = HRDATA;
		chk("hresp", 32'h0, HRESP);
	endtask : xfer
	task wst(input logic [1:0] s, input int lim);
		n = 0;
		while (PWR_STATE !== s && n < lim) begin
			@(posedge CORE_CLK);
			n++;
		end
	endtask : wst
	task cntl(input int k);
		n_st = 0;
		n_rt = 0;
		n_sp = 0;
		repeat (k) begin
			@(posedge CORE_CLK);
			n_st += int'(LED_STATE === 1'b1);
			n_rt += int'(LED_RADIO === 1'b1);
			n_sp += int'(SAMPLE === 1'b1);
		end
	endtask : cntl
	task results();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : results
	initial begin
		repeat (100000) @(posedge CORE_CLK);
		err_count++;
		results();
	end
	initial begin
		repeat (6) @(posedge CORE_CLK);
		RST <= 1'b0;
		cyc(4);
		chk("state", 32'h2, PWR_STATE);
		chk("radio_en", 32'h1, RADIO_EN);
		xfer(A_RTIV, 1'b0, 32'h0);
		chk("rt_iv", {24'h0, RTIV_RST}, rv);
		xfer(8'h18, 1'b0, 32'h0);
		chk("unmapped", 32'h0, rv);
		// hold sync is pulsed in every mode; only sample/hold obeys it
		for (int m = 0; m < 4; m++) begin
			xfer(A_CTRL, 1'b1, 32'(m << 1));
			cyc(5);
			HOLD_SYNC <= 1'b1;
			cntl(400);
			HOLD_SYNC <= 1'b0;
			chk("samples", (m == 1) ? 32'ha : {31'h0, m == 2}, n_sp);
		end
		xfer(A_ISTAT, 1'b0, 32'h0);
		chk("istat", 32'h8, rv & 32'h8);
		chk("irq_mask", 32'h0, IRQ);
		xfer(A_IMASK, 1'b1, 32'h8);
		cyc(3);
		chk("irq_on", 32'h1, IRQ);
		xfer(A_ISTAT, 1'b1, 32'h8);
		cyc(3);
		chk("irq_clr", 32'h0, IRQ);
		RADIO_LINK <= 1'b1;
		cyc(10);
		cntl(400);
		chk("led_link", 32'd200, n_rt);
		chk("led_awake", 32'd200, n_st);
		RADIO_LINK <= 1'b0;
		FAULT <= 1'b1;
		cyc(10);
		cntl(80);
		chk("led_nolink", 32'd80, n_rt);
		chk("led_fault", 32'd80, n_st);
		// fault set, no link, radio on, awake
		xfer(A_STAT, 1'b0, 32'h0);
		chk("status", 32'h2a, rv);
		FAULT <= 1'b0;
		host.msg(1'b1, 6);
		wst(2'h1, 30000);
		chk("radio_tmo", 32'h1, n > RADIO_TMO_T * TC - 40 &&
			n < RADIO_TMO_T * TC + 40);
		chk("radio_off", 32'h0, RADIO_EN);
		cyc(2);
		chk("led_dis", 32'h0, LED_RADIO);
		cntl(800);
		chk("led_sleep", 32'h0, n_st);
		host.msg(1'b0, 3);
		wst(2'h2, 20);
		chk("top_wake", 32'h2, PWR_STATE);
		wst(2'h1, 3000);
		chk("top_tmo", 32'h1, n > TOP_TMO_T * TC - 40 &&
			n < TOP_TMO_T * TC + 40);
		xfer(A_LOGIV, 1'b1, 32'hffff);
		xfer(A_CTRL, 1'b1, 32'h9);
		cyc(3);
		chk("radio_cmd", 32'h1, RADIO_EN);
		wst(2'h1, 30000);
		chk("asleep", 32'h1, PWR_STATE);
		cyc(5);
		cntl(800);
		chk("led_log", 32'd20, n_st);
		// 60 s interval: topside window ends at 30 s, lead wake at 45 s
		xfer(A_LOGIV, 1'b1, 32'd60);
		cyc(2);
		wst(2'h1, 3000);
		wst(2'h2, 1400);
		chk("sched_wake", 32'h2, PWR_STATE);
		chk("lead_time", 32'h1, n > 1120 && n < 1220);
		cntl(1300);
		chk("sched_sample", 32'h1, n_sp);
		xfer(A_CTRL, 1'b1, 32'h0);
		cyc(2);
		wst(2'h1, 3000);
		chk("pre_sensor", 32'h1, PWR_STATE);
		SENSOR_INS <= 1'b1;
		cyc(10);
		chk("sensor", 32'h2, PWR_STATE);
		SENSOR_INS <= 1'b0;
		wst(2'h1, 3000);
		chk("pre_magnet", 32'h1, PWR_STATE);
		chk("pre_mag_radio", 32'h0, RADIO_EN);
		MAGNET <= 1'b1;
		cyc(10);
		chk("magnet", 32'h2, PWR_STATE);
		chk("mag_radio", 32'h1, RADIO_EN);
		MAGNET <= 1'b0;
		results();
	end
endmodule : tb
